/* shared/dap_pkg.sv */
// Constants shared by the digital audio port and its pin selector
package dap_pkg;
  // Register byte offsets
  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] DATA_OFS   = 12'h040;
  localparam logic [11:0] DATA2_OFS  = 12'h0C0;
  localparam logic [11:0] STATUS_OFS = 12'h100;
  localparam logic [11:0] MODE_OFS   = 12'h600;
  localparam logic [11:0] SYS_OFS    = 12'h700;
  // Field positions
  localparam int CTRL_EN_BIT    = 16;
  localparam int CTRL_ECS_BIT   = 19;
  localparam int CTRL_TXM_BIT   = 8;
  localparam int CTRL_RXM_BIT   = 9;
  localparam int MODE_F64_BIT   = 0;
  localparam int MODE_PLL_BIT   = 1;
  localparam int MODE_DIV_LSB   = 8;
  localparam int MODE_DIV_W     = 7;
  localparam int SYS_SERIAL_PORT_SELECT_BIT = 0;
  localparam int SYS_F128_BIT   = 1;
  localparam int SYS_IMASK_BIT  = 2;
  localparam int DATA2_FEN_BIT  = 0;
  localparam int ST_TXHE_BIT    = 0;
  localparam int ST_RXHF_BIT    = 1;
  localparam int ST_UNDR_BIT    = 2;
  localparam int ST_OVR_BIT     = 3;
  localparam int ST_TXFULL_BIT  = 8;
  localparam int ST_RXEMPTY_BIT = 9;
  // Reset values and the status clear pattern
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [15:0] MODE_RST   = 16'h0000;
  localparam logic [2:0]  SYS_RST    = 3'h0;
  localparam logic [31:0] STATUS_CLR = 32'h0FFF_FFFF;
  // Frame geometry
  localparam int SAMPLE_W  = 16;
  localparam int TX_DEPTH  = 8;
  localparam int RX_DEPTH  = 12;
  localparam logic [7:0] MCLK_PER_FS = 8'hFF;
  // Shared pin indices
  localparam int PIN_CLK  = 0;
  localparam int PIN_TXFR = 1;
  localparam int PIN_TXDA = 2;
  localparam int PIN_RXDA = 3;
  localparam int PIN_RXFR = 4;
  // Pin owner selection
  typedef enum logic [2:0]
  {
    OWN_SER2  = 3'b001,
    OWN_CODEC = 3'b010,
    OWN_AUDIO = 3'b100
  } dap_owner_type;
endpackage

/* core/dap_core.sv */
// Digital audio serial port with sample FIFOs, clock divider and pin mux
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////

// Show-ahead FIFO with valid/ready on both sides
module dap_fifo #(
  parameter int W = 16,
  parameter int D = 8,
  parameter int LW = $clog2(D + 1)
) (
  // Clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rstn,
  // Fill side
  input  wire logic          i_in_valid,
  output logic               o_in_ready,
  input  wire logic [W-1:0]  i_in_data,
  // Drain side
  output logic               o_out_valid,
  input  wire logic          i_out_ready,
  output logic [W-1:0]       o_out_data,
  // Fill level
  output logic [LW-1:0]      o_level
);
  localparam int PW = $clog2(D);
  localparam logic [PW-1:0] LAST = PW'(D - 1);

  logic [W-1:0]  mem_r [D];
  logic [PW-1:0] wr_r;
  logic [PW-1:0] rd_r;
  logic [LW-1:0] cnt_r;
  wire           push = i_in_valid && o_in_ready;
  wire           pop  = o_out_valid && i_out_ready;

  assign o_in_ready  = (cnt_r != LW'(D));
  assign o_out_valid = (cnt_r != '0);
  assign o_out_data  = mem_r[rd_r];
  assign o_level     = cnt_r;

  always_ff @(posedge i_clk)
  begin
    if (push)
      mem_r[wr_r] <= i_in_data;
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
        wr_r <= (wr_r == LAST) ? '0 : wr_r + 1'b1;
      if (pop)
        rd_r <= (rd_r == LAST) ? '0 : rd_r + 1'b1;
      cnt_r <= cnt_r + LW'(push) - LW'(pop);
    end
  end
endmodule // dap_fifo

//////////////////////////////////////////////////////////////////////////////

module dap_core #(
  parameter int TXD = dap_pkg::TX_DEPTH,
  parameter int RXD = dap_pkg::RX_DEPTH
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // Register port
  input  wire logic [11:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata,
  // Global audio interrupt mask and fast interrupt
  output logic             o_fiq,
  // External audio-rate clock
  input  wire logic        i_ext_aclk,
  // Shared pins
  input  wire logic [4:0]  i_pin,
  output logic [4:0]       o_pin,
  output logic [4:0]       o_pin_oe,
  // Second serial port side
  input  wire logic [4:0]  i_ser2_o,
  input  wire logic [4:0]  i_ser2_oe,
  output logic [4:0]       o_ser2_i,
  // Codec port side
  input  wire logic [4:0]  i_codec_o,
  input  wire logic [4:0]  i_codec_oe,
  output logic [4:0]       o_codec_i
);
  localparam int TLW = $clog2(TXD + 1);
  localparam int RLW = $clog2(RXD + 1);

  // Bit of a sample sent at position p of a half frame, zero padding elsewhere
  function automatic logic frame_bit(input logic [15:0] s,
                                     input logic [5:0] p);
    logic [5:0] k;
    k = 6'd16 - p;
    frame_bit = (p >= 6'd1 && p <= 6'd16) ? s[k[3:0]] : 1'b0;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0] ctrl_r;
  logic [15:0] mode_r;
  logic [2:0]  sys_r;
  logic        fen_r;
  logic [3:0]  stat_r;
  logic [3:0]  stat_nxt;

  wire wr_ctrl = i_wr && i_addr == dap_pkg::CTRL_OFS;
  wire wr_data = i_wr && i_addr == dap_pkg::DATA_OFS;
  wire wr_d2   = i_wr && i_addr == dap_pkg::DATA2_OFS;
  wire wr_stat = i_wr && i_addr == dap_pkg::STATUS_OFS;
  wire wr_mode = i_wr && i_addr == dap_pkg::MODE_OFS;
  wire wr_sys  = i_wr && i_addr == dap_pkg::SYS_OFS;
  wire rd_data = i_rd && i_addr == dap_pkg::DATA_OFS;

  wire audio_en = ctrl_r[dap_pkg::CTRL_EN_BIT];
  wire f64      = mode_r[dap_pkg::MODE_F64_BIT];
  wire f128     = sys_r[dap_pkg::SYS_F128_BIT];
  wire mode_ok  = f64 ^ f128;
  wire ecs_ok   = !f64 || ctrl_r[dap_pkg::CTRL_ECS_BIT];
  wire run      = audio_en && mode_ok && ecs_ok;
  wire use_pll  = mode_r[dap_pkg::MODE_PLL_BIT];
  wire [6:0] div_fld = mode_r[dap_pkg::MODE_DIV_LSB +: dap_pkg::MODE_DIV_W];
  wire [6:0] div = (div_fld < 7'd2) ? 7'd2 : div_fld;

  //////////////////////////////////////////////////////////////////////////
  // Synchronisers for the data-in pin and the external clock
  logic [1:0] aclk_s_r;
  logic       aclk_d_r;
  logic [1:0] audio_serial_in_s_r;

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      aclk_s_r <= 2'h0;
      aclk_d_r <= 1'b0;
      audio_serial_in_s_r <= 2'h0;
    end
    else
    begin
      aclk_s_r <= {aclk_s_r[0], i_ext_aclk};
      aclk_d_r <= aclk_s_r[1];
      audio_serial_in_s_r <= {audio_serial_in_s_r[0], i_pin[dap_pkg::PIN_RXDA]};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Clock divider: master clock = source / divisor = 256 Fs
  // The system clock stands in for the internal PLL source; the audio
  // clocks are enables and registered pin levels, never clock nets.
  logic [6:0] div_cnt_r;
  logic [7:0] fs_cnt_r;
  logic       mclk_r;
  logic       bclk_r;
  logic       word_select_clock_r;
  logic       audio_serial_out_r;

  wire       ext_rise = aclk_s_r[1] && !aclk_d_r;
  wire       src_tick = run && (use_pll || ext_rise);
  wire       div_end  = div_cnt_r >= div - 7'd1;
  wire       mtick    = src_tick && div_end;
  wire [6:0] div_nxt  = div_end ? 7'd0 : div_cnt_r + 7'd1;
  wire [7:0] fs_nxt   = fs_cnt_r + 8'd1;
  wire [6:0] bidx     = f64 ? {1'b0, fs_nxt[7:2]} : fs_nxt[7:1];
  wire [5:0] pos      = f64 ? {1'b0, bidx[4:0]} : bidx[5:0];
  wire       chan_r   = fs_nxt[7];
  wire       b_edge   = f64 ? fs_nxt[1:0] == 2'b00 : !fs_nxt[0];
  wire       b_mid    = f64 ? fs_nxt[1:0] == 2'b10 : fs_nxt[0];
  wire       frm_beg  = fs_nxt == 8'h00;
  wire       frm_end  = fs_cnt_r == dap_pkg::MCLK_PER_FS;

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      div_cnt_r <= 7'd0;
      fs_cnt_r  <= dap_pkg::MCLK_PER_FS;
      mclk_r    <= 1'b0;
    end
    else if (!run)
    begin
      div_cnt_r <= 7'd0;
      fs_cnt_r  <= dap_pkg::MCLK_PER_FS;
      mclk_r    <= 1'b0;
    end
    else if (src_tick)
    begin
      div_cnt_r <= div_nxt;
      mclk_r    <= div_nxt < (div >> 1);
      if (mtick)
        fs_cnt_r <= fs_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sample FIFOs
  logic [15:0]    txl_q;
  logic [15:0]    txr_q;
  logic [15:0]    rxl_q;
  logic [15:0]    rxr_q;
  logic           txl_v;
  logic           txr_v;
  logic           rxl_v;
  logic           rxr_v;
  logic           txl_rdy;
  logic           txr_rdy;
  logic           rxl_rdy;
  logic           rxr_rdy;
  logic [TLW-1:0] txl_lvl;
  logic [TLW-1:0] txr_lvl;
  logic [RLW-1:0] rxl_lvl;
  logic [RLW-1:0] rxr_lvl;
  logic           rx_push_r;
  logic           rx_chan_r;
  logic [15:0]    rx_word_r;

  wire tx_pop = run && mtick && frm_end;
  wire rx_pop = rd_data && rxl_v && rxr_v;

  dap_fifo #(.W(16), .D(TXD)) u_txl (
    .i_clk       (i_clk),
    .i_rstn      (i_rstn),
    .i_in_valid  (wr_data),
    .o_in_ready  (txl_rdy),
    .i_in_data   (i_wdata[15:0]),
    .o_out_valid (txl_v),
    .i_out_ready (tx_pop),
    .o_out_data  (txl_q),
    .o_level     (txl_lvl)
  );

  dap_fifo #(.W(16), .D(TXD)) u_txr (
    .i_clk       (i_clk),
    .i_rstn      (i_rstn),
    .i_in_valid  (wr_data),
    .o_in_ready  (txr_rdy),
    .i_in_data   (i_wdata[31:16]),
    .o_out_valid (txr_v),
    .i_out_ready (tx_pop),
    .o_out_data  (txr_q),
    .o_level     (txr_lvl)
  );

  dap_fifo #(.W(16), .D(RXD)) u_rxl (
    .i_clk       (i_clk),
    .i_rstn      (i_rstn),
    .i_in_valid  (rx_push_r && !rx_chan_r),
    .o_in_ready  (rxl_rdy),
    .i_in_data   (rx_word_r),
    .o_out_valid (rxl_v),
    .i_out_ready (rx_pop),
    .o_out_data  (rxl_q),
    .o_level     (rxl_lvl)
  );

  dap_fifo #(.W(16), .D(RXD)) u_rxr (
    .i_clk       (i_clk),
    .i_rstn      (i_rstn),
    .i_in_valid  (rx_push_r && rx_chan_r),
    .o_in_ready  (rxr_rdy),
    .i_in_data   (rx_word_r),
    .o_out_valid (rxr_v),
    .i_out_ready (rx_pop),
    .o_out_data  (rxr_q),
    .o_level     (rxr_lvl)
  );

  //////////////////////////////////////////////////////////////////////////
  // Serial frame engine: MSB one bit after the word clock edge
  logic [15:0] tx_l_r;
  logic [15:0] tx_r_r;
  logic [14:0] rx_sh_r;

  wire [15:0] tx_cur = chan_r ? tx_r_r : tx_l_r;
  wire        rx_bit = pos >= 6'd1 && pos <= 6'd16;
  wire        rx_last = pos == 6'd16;
  wire        underrun = tx_pop && !(txl_v && txr_v);
  wire        overrun  = rx_push_r && !(rx_chan_r ? rxr_rdy : rxl_rdy);

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      tx_l_r    <= 16'h0000;
      tx_r_r    <= 16'h0000;
      rx_sh_r   <= 15'h0000;
      rx_push_r <= 1'b0;
      rx_chan_r <= 1'b0;
      rx_word_r <= 16'h0000;
      bclk_r    <= 1'b0;
      word_select_clock_r    <= 1'b0;
      audio_serial_out_r   <= 1'b0;
    end
    else
    begin
      rx_push_r <= 1'b0;
      if (!run)
      begin
        bclk_r  <= 1'b0;
        word_select_clock_r  <= 1'b0;
        audio_serial_out_r <= 1'b0;
      end
      else if (mtick)
      begin
        bclk_r <= f64 ? fs_nxt[1] : fs_nxt[0];
        word_select_clock_r <= chan_r;
        if (tx_pop)
        begin
          tx_l_r <= txl_v ? txl_q : 16'h0000;
          tx_r_r <= txr_v ? txr_q : 16'h0000;
        end
        if (b_edge && !frm_beg)
          audio_serial_out_r <= frame_bit(tx_cur, pos);
        else if (frm_beg)
          audio_serial_out_r <= 1'b0;
        if (b_mid && rx_bit)
        begin
          rx_sh_r <= {rx_sh_r[13:0], audio_serial_in_s_r[1]};
          if (rx_last)
          begin
            rx_word_r <= {rx_sh_r, audio_serial_in_s_r[1]};
            rx_chan_r <= chan_r;
            rx_push_r <= fen_r;
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Status, interrupt and register writes
  wire tx_half = txl_lvl <= TLW'(TXD / 2) || txr_lvl <= TLW'(TXD / 2);
  wire rx_half = rxl_lvl >= RLW'(RXD / 2) || rxr_lvl >= RLW'(RXD / 2);
  wire st_clr  = wr_stat && i_wdata == dap_pkg::STATUS_CLR;
  wire [3:0] st_set = {overrun, underrun, rx_half && fen_r,
                       tx_half && fen_r && run};

  // Set wins over the clear so no event slips through
  assign stat_nxt = (st_clr ? 4'h0 : stat_r) | st_set;

  wire irq_tx = stat_r[dap_pkg::ST_TXHE_BIT] && ctrl_r[dap_pkg::CTRL_TXM_BIT];
  wire irq_rx = stat_r[dap_pkg::ST_RXHF_BIT] && ctrl_r[dap_pkg::CTRL_RXM_BIT];

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ctrl_r <= dap_pkg::CTRL_RST;
      mode_r <= dap_pkg::MODE_RST;
      sys_r  <= dap_pkg::SYS_RST;
      fen_r  <= 1'b0;
      stat_r <= 4'h0;
      o_fiq  <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= i_wdata;
      if (wr_mode)
        mode_r <= i_wdata[15:0];
      if (wr_sys)
        sys_r <= i_wdata[2:0];
      if (wr_d2)
        fen_r <= i_wdata[dap_pkg::DATA2_FEN_BIT];
      stat_r <= stat_nxt;
      o_fiq  <= fen_r && sys_r[dap_pkg::SYS_IMASK_BIT] &&
                (irq_tx || irq_rx);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register read, answered one cycle after the strobe
  logic [31:0] rsel;
  logic [31:0] stat_word;

  always_comb
  begin
    stat_word = 32'h0000_0000;
    stat_word[3:0] = stat_r;
    stat_word[dap_pkg::ST_TXFULL_BIT]  = !(txl_rdy && txr_rdy);
    stat_word[dap_pkg::ST_RXEMPTY_BIT] = !(rxl_v && rxr_v);
    unique case (i_addr)
      dap_pkg::CTRL_OFS:   rsel = ctrl_r;
      dap_pkg::DATA_OFS:   rsel = {rxr_q, rxl_q};
      dap_pkg::DATA2_OFS:  rsel = {31'h0, fen_r};
      dap_pkg::STATUS_OFS: rsel = stat_word;
      dap_pkg::MODE_OFS:   rsel = {16'h0000, mode_r};
      dap_pkg::SYS_OFS:    rsel = {29'h0, sys_r};
      default:             rsel = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_rdata <= 32'h0000_0000;
    else if (i_rd)
      o_rdata <= rsel;
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin selector: exactly one owner drives and sees the shared pins
  dap_pkg::dap_owner_type owner;
  logic [4:0] aud_o;
  logic [4:0] aud_oe;

  assign owner = audio_en ? dap_pkg::OWN_AUDIO :
                 sys_r[dap_pkg::SYS_SERIAL_PORT_SELECT_BIT] ? dap_pkg::OWN_CODEC :
                 dap_pkg::OWN_SER2;

  // Bit clock, word clock, data out, data in, master clock
  assign aud_o  = {mclk_r, 1'b0, audio_serial_out_r, word_select_clock_r, bclk_r};
  assign aud_oe = 5'h17;

  always_comb
  begin
    unique case (owner)
      dap_pkg::OWN_AUDIO:
      begin
        o_pin    = aud_o;
        o_pin_oe = aud_oe;
      end
      dap_pkg::OWN_CODEC:
      begin
        o_pin    = i_codec_o;
        o_pin_oe = i_codec_oe;
      end
      default:
      begin
        o_pin    = i_ser2_o;
        o_pin_oe = i_ser2_oe;
      end
    endcase
  end

  assign o_ser2_i  = (owner == dap_pkg::OWN_SER2)  ? i_pin : 5'h00;
  assign o_codec_i = (owner == dap_pkg::OWN_CODEC) ? i_pin : 5'h00;
endmodule // dap_core

/* dv/dap_core_checker.sv */
// Concurrent checks on the audio port pin mux, frames and interrupt
`timescale 1ns/1ps
module dap_core_checker (
  // Clock, reset and register port
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic [11:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic        o_fiq,
  // Pins and the two other owners
  input wire logic [4:0]  i_pin,
  input wire logic [4:0]  o_pin,
  input wire logic [4:0]  o_pin_oe,
  input wire logic [4:0]  i_ser2_o,
  input wire logic [4:0]  i_ser2_oe,
  input wire logic [4:0]  o_ser2_i,
  input wire logic [4:0]  i_codec_o,
  input wire logic [4:0]  i_codec_oe,
  input wire logic [4:0]  o_codec_i
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  logic        en_r, sel_r, im_r, fen_r, msk_r;
  logic        bd_r, md_r, wd_r, wl_r, fv_r;
  logic [15:0] mode_r;
  logic [8:0]  mc_r, bc_r;
  logic [7:0]  idx_r;
  wire         b_rise = o_pin[0] && !bd_r;
  wire         m_rise = o_pin[4] && !md_r;
  wire         w_rise = o_pin[1] && !wd_r;
  wire         clr_wr = i_wr && i_addr == dap_pkg::STATUS_OFS
                        && i_wdata == dap_pkg::STATUS_CLR;
  //////////////////////////////////////////////////////////////////////////
  // Shadow of the control bits, kept from the bus writes
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      {en_r, msk_r, sel_r, im_r, fen_r, mode_r} <= 21'h0;
    end
    else if (i_wr)
    begin
      if (i_addr == dap_pkg::CTRL_OFS)
        {en_r, msk_r} <= {i_wdata[16], i_wdata[8] | i_wdata[9]};
      if (i_addr == dap_pkg::SYS_OFS)
        {im_r, sel_r} <= {i_wdata[2], i_wdata[0]};
      if (i_addr == dap_pkg::DATA2_OFS)
        fen_r <= i_wdata[0];
      if (i_addr == dap_pkg::MODE_OFS)
        mode_r <= i_wdata[15:0];
    end
  end
  // Edge counts per frame; the first frame after enable is partial
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      {bd_r, md_r, wd_r, wl_r, fv_r, mc_r, bc_r, idx_r} <= 31'h0;
    end
    else
    begin
      {bd_r, md_r, wd_r} <= {o_pin[0], o_pin[4], o_pin[1]};
      fv_r <= en_r && (fv_r || w_rise);
      mc_r <= w_rise ? {8'h0, m_rise} : mc_r + {8'h0, m_rise};
      bc_r <= w_rise ? {8'h0, b_rise} : bc_r + {8'h0, b_rise};
      if (b_rise)
        wl_r <= o_pin[1];
      if (b_rise)
        idx_r <= (o_pin[1] != wl_r) ? 8'h0 : idx_r + 8'h1;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  a_serial_owns: assert property (!en_r && !sel_r |-> o_pin == i_ser2_o
    && o_pin_oe == i_ser2_oe && o_ser2_i == i_pin && o_codec_i == 5'h0)
    else $error("serial port not routed to pins");
  a_codec_owns: assert property (!en_r && sel_r |-> o_pin == i_codec_o
    && o_pin_oe == i_codec_oe && o_codec_i == i_pin && o_ser2_i == 5'h0)
    else $error("codec port not routed to pins");
  a_audio_dirs: assert property (en_r |-> o_pin_oe == 5'h17
    && o_ser2_i == 5'h0 && o_codec_i == 5'h0)
    else $error("audio pin directions wrong");
  a_fiq_gated: assert property (o_fiq |-> $past(fen_r && im_r && msk_r))
    else $error("interrupt without all enables");
  a_status_clear: assert property (clr_wr && !en_r |-> ##[1:2] !o_fiq)
    else $error("interrupt stays after status clear");
  a_mode_readback: assert property (i_rd && i_addr == dap_pkg::MODE_OFS
    |=> o_rdata[15:0] == $past(mode_r))
    else $error("mode register readback wrong");
  a_mclk_ratio: assert property (w_rise && fv_r |-> mc_r == 9'h100)
    else $error("master clock not 256 per frame");
  a_bclk_count: assert property (w_rise && fv_r
    |-> bc_r == (mode_r[0] ? 9'h040 : 9'h080))
    else $error("bit clocks per frame wrong");
  a_pad_zero: assert property (b_rise && fv_r && o_pin[1] == wl_r
    && idx_r >= 8'h10 |-> !o_pin[2])
    else $error("padding bit not zero");
endmodule
// dap_core_checker

bind dap_core dap_core_checker u_dap_core_checker (.i_clk(i_clk),
  .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .o_fiq(o_fiq), .i_pin(i_pin),
  .o_pin(o_pin), .o_pin_oe(o_pin_oe), .i_ser2_o(i_ser2_o),
  .i_ser2_oe(i_ser2_oe), .o_ser2_i(o_ser2_i), .i_codec_o(i_codec_o),
  .i_codec_oe(i_codec_oe), .o_codec_i(o_codec_i));

/* dv/dap_audio_model.sv */
// External converter pair: hears the port's frames and feeds it samples
`timescale 1ns/1ps
module dap_audio_model (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // Audio pins seen from the converters
  input  wire logic        i_bclk,
  input  wire logic        i_wclk,
  input  wire logic        i_sdo,
  output logic             o_sdi,
  // Samples sent and frames heard
  input  wire logic [15:0] i_rx_left,
  input  wire logic [15:0] i_rx_right,
  output logic [15:0]      o_left,
  output logic [15:0]      o_right,
  output logic             o_done
);
  logic        bd_r, wl_r;
  logic [7:0]  pos_r, nxt;
  logic [15:0] sh_r, word;
  assign nxt  = (i_wclk != wl_r) ? 8'h00 : pos_r + 8'h01;
  assign word = i_wclk ? i_rx_right : i_rx_left;
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      {bd_r, wl_r, pos_r, sh_r} <= {2'h0, 8'hFF, 16'h0};
      {o_left, o_right, o_done} <= 33'h0;
      // Line not driven: keep it moving so no stale bit is heard
      o_sdi <= (o_sdi === 1'h0);
    end
    else
    begin
      bd_r   <= i_bclk;
      o_done <= 1'h0;
      if (i_bclk && !bd_r)
      begin
        wl_r  <= i_wclk;
        pos_r <= nxt;
        if (nxt >= 8'h01 && nxt <= 8'h10)
          sh_r <= {sh_r[14:0], i_sdo};
        if (nxt == 8'h00 && i_wclk)
          o_left <= sh_r;
        if (nxt == 8'h00 && !i_wclk)
          {o_right, o_done} <= {sh_r, 1'h1};
      end
      if (!i_bclk && bd_r)
        o_sdi <= (nxt >= 8'h01 && nxt <= 8'h10) ? word[5'h10 - nxt[4:0]]
                                                : ~o_sdi;
    end
  end
endmodule
// dap_audio_model

/* dv/tb_digital_audio_port_with_pin_mux.sv */
// Self-checking bench for the digital audio port with pin mux
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module tb_digital_audio_port_with_pin_mux;
  logic        i_clk = 1'h0, i_rstn = 1'h0, wr_s = 1'h0, rd_s = 1'h0;
  logic        ext = 1'h0;
  logic [11:0] addr = 12'h0;
  logic [31:0] wdata = 32'h0, d, rv;
  logic [4:0]  prn = 5'h0, s2o = 5'h0, s2oe = 5'h0, co = 5'h0, coe = 5'h0;
  logic [15:0] rx_l = 16'h0, rx_r = 16'h0;
  wire  [31:0] rdata;
  wire  [15:0] cl, cr;
  wire  [4:0]  po, poe, s2i, coi, pin;
  wire         fiq, sdi, fdone;
  int          fail_count = 0, checks = 0, cyc = 0, n = 0;
  logic [31:0] q[$], tx[8];
  assign pin = {prn[4], sdi, prn[2:0]};
  always #2 i_clk = ~i_clk;
  // External audio clock, unrelated to the system clock
  always #7 ext = ~ext;
  dap_core u_dap_core (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata),
    .o_fiq(fiq), .i_ext_aclk(ext), .i_pin(pin), .o_pin(po),
    .o_pin_oe(poe), .i_ser2_o(s2o), .i_ser2_oe(s2oe), .o_ser2_i(s2i),
    .i_codec_o(co), .i_codec_oe(coe), .o_codec_i(coi));
  // Converters only listen while the word clock pin is driven as an output
  dap_audio_model u_dap_audio_model (.i_clk(i_clk),
    .i_rstn(i_rstn && poe[1]), .i_bclk(po[0]), .i_wclk(po[1]),
    .i_sdo(po[2]), .o_sdi(sdi), .i_rx_left(rx_l), .i_rx_right(rx_r),
    .o_left(cl), .o_right(cr), .o_done(fdone));
  //////////////////////////////////////////////////////////////////////////
  always @(posedge i_clk)
  begin
    cyc++;
    if (fdone)
      q.push_back({cr, cl});
    if (cyc == 70000)
    begin
      fail_count++;
      stop_test();
    end
  end
  function automatic logic [19:0] exp_mux(input logic sel);
    return sel ? {co, coe, 5'h0, pin} : {s2o, s2oe, pin, 5'h0};
  endfunction
  function automatic int first_nz(input int from);
    for (int k = from; k < q.size(); k++)
      if (q[k] !== 32'h0)
        return k;
    return from;
  endfunction
  task wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge i_clk);
    {addr, wdata, wr_s} <= {a, v, 1'h1};
    @(posedge i_clk);
    wr_s <= 1'h0;
  endtask
  task rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge i_clk);
    {addr, rd_s} <= {a, 1'h1};
    @(posedge i_clk);
    rd_s <= 1'h0;
    @(negedge i_clk);
    v = rdata;
  endtask
  task stop_test();
    if (fail_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'hd42d));
    repeat (6) @(posedge i_clk);
    i_rstn <= 1'h1;
    // Second serial port and codec traffic with the internal source selected
    wr(dap_pkg::MODE_OFS, 32'h0002);
    for (int k = 0; k < 8; k++)
    begin
      rv = $urandom;
      {prn, s2o, s2oe, co, coe} <= rv[24:0];
      wr(dap_pkg::SYS_OFS, {31'h0, rv[31]});
      @(negedge i_clk);
      `CHK({po, poe, s2i, coi}, exp_mux(rv[31]))
    end
    // Keep the converters in reset until the audio port drives the pins
    {s2oe, coe} <= 10'h0;
    rd(12'h004, d);
    `CHK(d, 32'h0)
    // 128-bit frames, internal source, divisor 8 (Fs = system clock / 2048), global and TX interrupt masks open
    // A divisor this large also leaves room for the input synchroniser
    wr(dap_pkg::SYS_OFS, 32'h6);
    wr(dap_pkg::MODE_OFS, 32'h0802);
    wr(dap_pkg::DATA2_OFS, 32'h1);
    rd(dap_pkg::MODE_OFS, d);
    `CHK(d[15:0], 16'h0802)
    rv = $urandom;
    {rx_r, rx_l} <= rv;
    for (int k = 0; k < 8; k++)
    begin
      tx[k] = $urandom | 32'h0001_0001;
      wr(dap_pkg::DATA_OFS, tx[k]);
    end
    rd(dap_pkg::STATUS_OFS, d);
    `CHK(d[8], 1'h1)
    wr(dap_pkg::DATA_OFS, 32'hFFFF_FFFF);
    wr(dap_pkg::CTRL_OFS, 32'h0001_0100);
    @(negedge i_clk);
    `CHK(poe, 5'h17)
    while (fiq !== 1'h1)
      @(posedge i_clk);
    while (q.size() < 16)
      @(posedge i_clk);
    wr(dap_pkg::CTRL_OFS, 32'h0000_0100);
    n = first_nz(0);
    for (int k = 0; k < 8; k++)
      `CHK(q[n + k], tx[k])
    `CHK(q[n + 8], 32'h0)
    rd(dap_pkg::STATUS_OFS, d);
    `CHK({d[9:8], d[3:0]}, 6'h0F)
    wr(dap_pkg::SYS_OFS, 32'h2);
    repeat (2) @(negedge i_clk);
    `CHK(fiq, 1'h0)
    wr(dap_pkg::SYS_OFS, 32'h6);
    repeat (2) @(negedge i_clk);
    `CHK(fiq, 1'h1)
    wr(dap_pkg::STATUS_OFS, dap_pkg::STATUS_CLR);
    rd(dap_pkg::STATUS_OFS, d);
    // RX FIFOs are still half full, so that bit sets again at once
    `CHK({fiq, d[3:0]}, 5'h02)
    for (int k = 0; k < 12; k++)
    begin
      rd(dap_pkg::DATA_OFS, d);
      `CHK(d, rv)
    end
    rd(dap_pkg::STATUS_OFS, d);
    `CHK(d[9], 1'h1)
    // 64-bit frames from the external clock; clocks wait for EXTERNAL_CLOCK_SELECT
    wr(dap_pkg::SYS_OFS, 32'h4);
    wr(dap_pkg::MODE_OFS, 32'h0201);
    wr(dap_pkg::CTRL_OFS, 32'h0001_0000);
    wr(dap_pkg::DATA_OFS, tx[1]);
    n = q.size();
    repeat (4000) @(posedge i_clk);
    `CHK(q.size(), n)
    wr(dap_pkg::CTRL_OFS, 32'h0009_0000);
    while (q.size() < n + 4)
      @(posedge i_clk);
    `CHK(q[first_nz(n)], tx[1])
    stop_test();
  end
endmodule
// tb_digital_audio_port_with_pin_mux
